// file: src/shift_if.sv
// Purpose: Link between the control block and its shift engine
// Assumes: Both ends run on the same clock
// Notes:   Pin inputs arrive here already synchronised
`timescale 1ns/100ps
`default_nettype none
interface shift_if;
    logic       en;         // Module enable, clears engine when low
    logic       run;        // Low while clocks are stopped in wait
    logic       master;
    logic       clock_polarity;
    logic       clock_phase;
    logic       lsb_first;
    logic       tick;       // Master half-period enable pulse
    logic       load;       // Take load_data into the shifter
    logic [7:0] load_data;
    logic       sclk_in;
    logic       sel_n_in;
    logic       din;
    logic       busy;
    logic       done;       // One-cycle pulse, rx_data valid
    logic [7:0] rx_data;
    logic       dout;
    logic       sclk_out;

    modport ctrl (output en, run, master, clock_polarity, clock_phase, lsb_first, tick, load, load_data,
                  sclk_in, sel_n_in, din, input busy, done, rx_data, dout, sclk_out);
    modport engine (input en, run, master, clock_polarity, clock_phase, lsb_first, tick, load, load_data,
                    sclk_in, sel_n_in, din, output busy, done, rx_data, dout, sclk_out);
endinterface
`default_nettype wire

// file: src/spi_cfg_pkg.sv
// Purpose: Shared constants for the serial peripheral control block
// Assumes: 32-bit AHB-Lite register bus, one register per aligned word
// Notes:   Offsets are byte addresses within the block's window
package spi_cfg_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
    localparam logic [7:0] ADDR_BAUD     = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0C;
    localparam logic [7:0] ADDR_DATA     = 8'h10;
    localparam logic [7:0] ADDR_EVENT    = 8'h14;
    localparam logic [7:0] ADDR_MASK     = 8'h18;
    // Control one field positions
    localparam int RX_IRQ_EN_BIT = 7;
    localparam int MOD_EN_BIT    = 6;
    localparam int TX_IRQ_EN_BIT = 5;
    localparam int MASTER_BIT    = 4;
    localparam int CLOCK_POLARITY_BIT      = 3;
    localparam int CLOCK_PHASE_BIT      = 2;
    localparam int SEL_OE_BIT    = 1;
    localparam int LSB_FIRST_BIT = 0;
    // Control two field positions and implemented bits
    localparam int FAULT_EN_BIT    = 4;
    localparam int SW_OE_BIT       = 3;
    localparam int WAIT_STOP_BIT   = 1;
    localparam int SINGLE_WIRE_BIT = 0;
    localparam logic [7:0] CTRL_TWO_IMPL = 8'h1B;
    // Status field positions
    localparam int RX_FULL_BIT  = 7;
    localparam int TX_EMPTY_BIT = 5;
    localparam int FAULT_BIT    = 4;
    // Event register layout
    localparam int EVT_W         = 3;
    localparam int EVT_RX_BIT    = 0;
    localparam int EVT_TX_BIT    = 1;
    localparam int EVT_FAULT_BIT = 2;
    // Reset values
    localparam logic [7:0] CTRL_ONE_RST = 8'h04;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    localparam logic [7:0] BAUD_RST     = 8'h03;
    localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
    // Count of the last bit of a word, eight serial clock cycles long
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Shift one bit into a word in the selected direction
    function automatic logic [7:0] shift_in(input logic [7:0] w, input logic b,
                                            input logic lsb_first);
        shift_in = lsb_first ? {b, w[7:1]} : {w[6:0], b};
    endfunction
endpackage

// file: src/spi_control_config.sv
// Purpose: Serial peripheral control registers, pin steering and bus slave
// Assumes: Single AHB-Lite master, pins synchronised here, one clock
// Notes:   Register reads take one wait state, writes take none
`timescale 1ns/100ps
`default_nettype none
module spi_control_config
    import spi_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Processor state and interrupt
    input  wire logic        wait_mode_i,
    output logic             irq_o,
    // Serial clock pin
    input  wire logic        sclk_i,
    output logic             sclk_o,
    output logic             sclk_oe_o,
    // Master data out pin
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe_o,
    // Master data in pin
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    // Select pin, active low
    input  wire logic        sel_n_i,
    output logic             sel_n_o,
    output logic             sel_n_oe_o
);
    shift_if sif ();

    // Bus state
    logic        dp_write, next_dp_write, rd_pend, next_rd_pend;
    logic [7:0]  dp_addr, next_dp_addr, rd8;
    logic [31:0] next_hrdata;
    logic        next_hready, addr_ok;
    // Register state
    logic [7:0]  ctrl_one, next_ctrl_one, ctrl_two, next_ctrl_two;
    logic [7:0]  baud, next_baud, tx_buf, next_tx_buf, rx_buf, next_rx_buf;
    logic [7:0]  div_cnt, next_div_cnt;
    logic        tx_full, next_tx_full, rx_full, next_rx_full;
    logic        mode_fault, next_mode_fault, tick, next_tick;
    logic        arm_rx, next_arm_rx, arm_tx, next_arm_tx;
    logic        arm_fault, next_arm_fault, next_irq;
    logic [EVT_W-1:0] evt, next_evt, mask, next_mask;
    // Pin synchronisers, first stage read only by the second
    logic [3:0]  pin_meta, pin_sync;
    logic        sclk_s, mosi_s, miso_s, sel_s;
    logic        next_sclk, next_sclk_oe, next_mosi, next_mosi_oe;
    logic        next_miso, next_miso_oe, next_sel, next_sel_oe;
    // Decoded controls
    logic        en, run, master, single, fault_in_mode;

    assign sclk_s = pin_sync[3];
    assign mosi_s = pin_sync[2];
    assign miso_s = pin_sync[1];
    assign sel_s  = pin_sync[0];
    assign en     = ctrl_one[MOD_EN_BIT];
    assign run    = ~(ctrl_two[WAIT_STOP_BIT] & wait_mode_i);
    // role bit steers engine and pins
    assign master = ctrl_one[MASTER_BIT];
    assign single = ctrl_two[SINGLE_WIRE_BIT];
    // fault input only when fault on, select output off
    assign fault_in_mode = master & ctrl_two[FAULT_EN_BIT] & ~ctrl_one[SEL_OE_BIT];

    // Engine hookup
    assign sif.en        = en;
    assign sif.run       = run;
    assign sif.master    = master;
    assign sif.clock_polarity      = ctrl_one[CLOCK_POLARITY_BIT];
    assign sif.clock_phase      = ctrl_one[CLOCK_PHASE_BIT];
    assign sif.lsb_first = ctrl_one[LSB_FIRST_BIT];
    assign sif.tick      = tick;
    assign sif.load      = en & run & tx_full & ~sif.busy;
    assign sif.load_data = tx_buf;
    assign sif.sclk_in   = sclk_s;
    // select input always used by slave
    assign sif.sel_n_in  = sel_s;
    // data input pin picked by role and wiring
    assign sif.din       = (master ^ single) ? miso_s : mosi_s;

    spi_shift_engine u_engine (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .sif     (sif.engine)
    );

    // Bus phases and read mux
    always_comb begin
        addr_ok       = hsel_i & htrans_i[1] & hready_i;
        next_dp_write = addr_ok & hwrite_i;
        next_rd_pend  = addr_ok & ~hwrite_i;
        next_dp_addr  = addr_ok ? haddr_i[7:0] : dp_addr;
        // Reads stall one cycle so hrdata can leave a flop
        next_hready   = ~(addr_ok & ~hwrite_i);
        rd8 = 8'h00;
        case (dp_addr)
            ADDR_CTRL_ONE: rd8 = ctrl_one;
            ADDR_CTRL_TWO: rd8 = ctrl_two & CTRL_TWO_IMPL;
            ADDR_BAUD:     rd8 = baud;
            ADDR_STATUS: begin
                rd8[RX_FULL_BIT]  = rx_full;
                rd8[TX_EMPTY_BIT] = ~tx_full;
                rd8[FAULT_BIT]    = mode_fault;
            end
            ADDR_DATA:     rd8 = rx_buf;
            ADDR_EVENT:    rd8[EVT_W-1:0] = evt;
            ADDR_MASK:     rd8[EVT_W-1:0] = mask;
            default:       rd8 = 8'h00;
        endcase
        next_hrdata = rd_pend ? {24'h000000, rd8} : hrdata_o;
    end

    // Bus registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dp_write    <= 1'b0;
            rd_pend     <= 1'b0;
            dp_addr     <= 8'h00;
            hrdata_o    <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            dp_write    <= next_dp_write;
            rd_pend     <= next_rd_pend;
            dp_addr     <= next_dp_addr;
            hrdata_o    <= next_hrdata;
            hreadyout_o <= next_hready;
            hresp_o     <= 1'b0;
        end
    end

    // Registers, flags, divider and interrupt
    always_comb begin
        next_ctrl_one   = ctrl_one;
        next_ctrl_two   = ctrl_two;
        next_baud       = baud;
        next_tx_buf     = tx_buf;
        next_tx_full    = tx_full;
        next_rx_buf     = rx_buf;
        next_rx_full    = rx_full;
        next_mode_fault = mode_fault;
        next_arm_rx     = arm_rx;
        next_arm_tx     = arm_tx;
        next_arm_fault  = arm_fault;
        next_evt        = evt;
        next_mask       = mask;
        next_tick       = 1'b0;
        next_div_cnt    = 8'h00;
        // Half-period divider runs only during a master word
        if (en && run && master && sif.busy && !tick) begin
            if (div_cnt == baud) begin
                next_tick = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 8'h01;
            end
        end
        if (sif.load) begin
            next_tx_full = 1'b0;
        end
        // Status read arms the clear sequences
        if (rd_pend && dp_addr == ADDR_STATUS) begin
            next_arm_rx    = rx_full;
            next_arm_tx    = ~tx_full;
            next_arm_fault = mode_fault;
        end
        if (rd_pend && dp_addr == ADDR_DATA && arm_rx) begin
            next_rx_full = 1'b0;
            next_arm_rx  = 1'b0;
        end
        if (dp_write) begin
            case (dp_addr)
                ADDR_CTRL_ONE: begin
                    next_ctrl_one = hwdata_i[7:0];
                    if (arm_fault) begin
                        next_mode_fault = 1'b0;
                        next_arm_fault  = 1'b0;
                    end
                end
                ADDR_CTRL_TWO: next_ctrl_two = hwdata_i[7:0] & CTRL_TWO_IMPL;
                ADDR_BAUD:     next_baud = hwdata_i[7:0];
                ADDR_DATA: begin
                    if (arm_tx && !tx_full && en) begin
                        next_tx_buf  = hwdata_i[7:0];
                        next_tx_full = 1'b1;
                        next_arm_tx  = 1'b0;
                    end
                end
                ADDR_EVENT:    next_evt = evt & ~hwdata_i[EVT_W-1:0];
                ADDR_MASK:     next_mask = hwdata_i[EVT_W-1:0];
                default:       next_evt = evt;
            endcase
        end
        // fault input pulled low; set wins over clear
        if (en && fault_in_mode && !sel_s) begin
            next_mode_fault           = 1'b1;
            next_ctrl_one[MASTER_BIT] = 1'b0;
        end
        // Completed word, set wins over the data-read clear
        if (sif.done) begin
            next_rx_buf  = sif.rx_data;
            next_rx_full = 1'b1;
        end
        // disabled block: empty buffers, transmit shows empty
        if (!en) begin
            next_tx_full = 1'b0;
            next_rx_full = 1'b0;
            next_arm_rx  = 1'b0;
            next_arm_tx  = 1'b0;
        end
        // Sticky events on rising flags, after any clear
        next_evt[EVT_RX_BIT]    = next_evt[EVT_RX_BIT] | (next_rx_full & ~rx_full);
        next_evt[EVT_TX_BIT]    = next_evt[EVT_TX_BIT] | (~next_tx_full & tx_full);
        next_evt[EVT_FAULT_BIT] = next_evt[EVT_FAULT_BIT] | (next_mode_fault & ~mode_fault);
        next_irq = next_ctrl_one[RX_IRQ_EN_BIT] & (next_rx_full | next_mode_fault);
        next_irq = next_irq | (next_ctrl_one[TX_IRQ_EN_BIT] & ~next_tx_full);
        next_irq = next_irq | (|(next_evt & next_mask));
    end

    // Register file flops
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl_one   <= CTRL_ONE_RST;
            ctrl_two   <= CTRL_TWO_RST;
            baud       <= BAUD_RST;
            tx_buf     <= 8'h00;
            tx_full    <= 1'b0;
            rx_buf     <= 8'h00;
            rx_full    <= 1'b0;
            mode_fault <= 1'b0;
            arm_rx     <= 1'b0;
            arm_tx     <= 1'b0;
            arm_fault  <= 1'b0;
            evt        <= 3'h0;
            mask       <= MASK_RST;
            tick       <= 1'b0;
            div_cnt    <= 8'h00;
            irq_o      <= 1'b0;
        end else begin
            ctrl_one   <= next_ctrl_one;
            ctrl_two   <= next_ctrl_two;
            baud       <= next_baud;
            tx_buf     <= next_tx_buf;
            tx_full    <= next_tx_full;
            rx_buf     <= next_rx_buf;
            rx_full    <= next_rx_full;
            mode_fault <= next_mode_fault;
            arm_rx     <= next_arm_rx;
            arm_tx     <= next_arm_tx;
            arm_fault  <= next_arm_fault;
            evt        <= next_evt;
            mask       <= next_mask;
            tick       <= next_tick;
            div_cnt    <= next_div_cnt;
            irq_o      <= next_irq;
        end
    end

    // Pin steering
    always_comb begin
        next_sclk_oe = en & master;
        next_sclk    = sif.sclk_out;
        next_mosi_oe = en & master & (~single | ctrl_two[SW_OE_BIT]);
        next_mosi    = sif.dout;
        // Slave drives only while selected, avoiding bus fights
        next_miso_oe = en & ~master & ~sel_s & (~single | ctrl_two[SW_OE_BIT]);
        next_miso    = sif.dout;
        // automatic select output, low during a word
        next_sel_oe  = en & master & ctrl_two[FAULT_EN_BIT] & ctrl_one[SEL_OE_BIT];
        next_sel     = ~sif.busy;
    end

    // Pin flops and input synchronisers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pin_meta   <= 4'hF;
            pin_sync   <= 4'hF;
            sclk_o     <= 1'b0;
            sclk_oe_o  <= 1'b0;
            mosi_o     <= 1'b0;
            mosi_oe_o  <= 1'b0;
            miso_o     <= 1'b0;
            miso_oe_o  <= 1'b0;
            sel_n_o    <= 1'b1;
            sel_n_oe_o <= 1'b0;
        end else begin
            pin_meta   <= {sclk_i, mosi_i, miso_i, sel_n_i};
            pin_sync   <= pin_meta;
            sclk_o     <= next_sclk;
            sclk_oe_o  <= next_sclk_oe;
            mosi_o     <= next_mosi;
            mosi_oe_o  <= next_mosi_oe;
            miso_o     <= next_miso;
            miso_oe_o  <= next_miso_oe;
            sel_n_o    <= next_sel;
            sel_n_oe_o <= next_sel_oe;
        end
    end
endmodule
`default_nettype wire

// file: src/spi_shift_engine.sv
// Purpose: Eight-bit shift engine for master and slave roles
// Assumes: Inputs synchronised by the caller; tick is a one-cycle pulse
// Notes:   Clock edges are named lead and trail after polarity is removed
`timescale 1ns/100ps
`default_nettype none
module spi_shift_engine
    import spi_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Control side
    shift_if.engine   sif
);
    logic [7:0] sr, next_sr, rx, next_rx;
    logic [2:0] cnt, next_cnt;
    logic       in_bit, next_in_bit;
    logic       phase, next_phase;
    logic       busy, next_busy;
    logic       done, next_done;
    logic       s_prev, next_s_prev;
    logic       lead, trail, s_now;

    // Next state of shifter, edge decode included
    always_comb begin
        next_sr     = sr;
        next_rx     = rx;
        next_cnt    = cnt;
        next_in_bit = in_bit;
        next_phase  = phase;
        next_busy   = busy;
        next_done   = 1'b0;
        s_now       = sif.sclk_in ^ sif.clock_polarity;
        next_s_prev = s_now;
        if (sif.master) begin
            lead  = sif.run & busy & sif.tick & ~phase;
            trail = sif.run & busy & sif.tick & phase;
        end else begin
            lead  = sif.run & ~sif.sel_n_in & s_now & ~s_prev;
            trail = sif.run & ~sif.sel_n_in & ~s_now & s_prev;
        end
        if (!sif.en) begin
            next_sr    = 8'h00;
            next_cnt   = 3'h0;
            next_phase = 1'b0;
            next_busy  = 1'b0;
        end else if (sif.run) begin
            if (sif.load && !busy) begin
                next_sr    = sif.load_data;
                next_busy  = 1'b1;
                next_cnt   = 3'h0;
                next_phase = 1'b0;
            end
            // Deselect mid-byte aborts the slave word
            if (!sif.master && sif.sel_n_in) begin
                next_cnt   = 3'h0;
                next_phase = 1'b0;
            end
            // sample and shift edges by phase
            if (lead) begin
                next_phase = 1'b1;
                if (!sif.clock_phase) begin
                    next_in_bit = sif.din;
                end else if (cnt != 3'h0) begin
                    next_sr = shift_in(sr, in_bit, sif.lsb_first);
                end
            end
            if (trail) begin
                next_phase = 1'b0;
                next_cnt   = cnt + 3'h1;
                if (!sif.clock_phase) begin
                    next_sr = shift_in(sr, in_bit, sif.lsb_first);
                end else begin
                    next_in_bit = sif.din;
                end
                if (cnt == LAST_BIT) begin
                    next_done = 1'b1;
                    next_busy = 1'b0;
                    next_cnt  = 3'h0;
                    next_rx   = sif.clock_phase ? shift_in(sr, sif.din, sif.lsb_first)
                                         : shift_in(sr, in_bit, sif.lsb_first);
                end
            end
        end
    end

    // Shifter registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sr     <= 8'h00;
            rx     <= 8'h00;
            cnt    <= 3'h0;
            in_bit <= 1'b0;
            phase  <= 1'b0;
            busy   <= 1'b0;
            done   <= 1'b0;
            s_prev <= 1'b0;
        end else begin
            sr     <= next_sr;
            rx     <= next_rx;
            cnt    <= next_cnt;
            in_bit <= next_in_bit;
            phase  <= next_phase;
            busy   <= next_busy;
            done   <= next_done;
            s_prev <= next_s_prev;
        end
    end

    // Outputs toward control side
    assign sif.busy     = busy;
    assign sif.done     = done;
    assign sif.rx_data  = rx;
    assign sif.dout     = sif.lsb_first ? sr[0] : sr[7];
    assign sif.sclk_out = sif.clock_polarity ^ phase;
endmodule
`default_nettype wire

// file: verif/spi_cc_asserts.sv
// Purpose: Port assertions for the serial control block
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only top-level ports
`timescale 1ns/100ps
`default_nettype none
module spi_cc_asserts (
    // Clock, reset and bus
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic       hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic       hwrite_i,
    input wire logic       hready_i,
    input wire logic       hreadyout_o,
    input wire logic       hresp_o,
    // Interrupt and pins
    input wire logic       irq_o,
    input wire logic       sclk_o,
    input wire logic       sclk_oe_o,
    input wire logic       mosi_oe_o,
    input wire logic       miso_oe_o,
    input wire logic       sel_n_o,
    input wire logic       sel_n_oe_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Accepted address phase
    wire logic take = hsel_i && htrans_i[1] && hready_i;
    sequence s_read_data;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    // Bus timing as handed over
    a_read_wait: assert property (take && !hwrite_i |=> s_read_data)
        else $error("read wait state wrong");
    a_write_fast: assert property (take && hwrite_i |=> hreadyout_o)
        else $error("write stalled");
    a_resp_okay: assert property (!hresp_o) else $error("error response");
    // Pin steering by role and mode
    a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !sel_n_oe_o
        && !(sclk_oe_o || mosi_oe_o || miso_oe_o)) else $error("pins driven after reset");
    a_master_miso: assert property (!(sclk_oe_o && miso_oe_o))
        else $error("master drove data in");
    a_one_data: assert property (!(mosi_oe_o && miso_oe_o))
        else $error("two data drivers");
    a_sel_master: assert property (sel_n_oe_o |-> sclk_oe_o)
        else $error("select driven as slave");
    // Clock moves only inside a selected frame
    a_clk_framed: assert property ($changed(sclk_o) && $past(sel_n_oe_o) && sel_n_oe_o
        |-> !sel_n_o || !$past(sel_n_o)) else $error("clock outside frame");
endmodule
bind spi_control_config spi_cc_asserts u_chk (.clock_i(clock_i), .rst_i(rst_i),
    .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .irq_o(irq_o), .sclk_o(sclk_o),
    .sclk_oe_o(sclk_oe_o), .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o),
    .sel_n_o(sel_n_o), .sel_n_oe_o(sel_n_oe_o));
`default_nettype wire

// file: verif/spi_slave_model.sv
// Purpose: Behavioural serial slave on the far side of the pins
// Assumes: Polarity 0, phase 0, most significant bit first
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/100ps
`default_nettype none
module spi_slave_model (
    // Serial pins
    input  wire logic       sclk_i,
    input  wire logic       sel_n_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // Captured word
    output logic [7:0]      rx_o
);
    logic [7:0] tx = 8'h00;
    always @(negedge sel_n_i) tx = 8'h96;
    always @(posedge sclk_i) if (!sel_n_i) rx_o <= {rx_o[6:0], mosi_i};
    always @(negedge sclk_i) if (!sel_n_i) tx <= {tx[6:0], 1'b0};
    // No pull on the line, so it never keeps a stale bit
    initial miso_o = 1'b0;
    always @(sel_n_i or tx) miso_o = sel_n_i ? ~miso_o : tx[7];
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Purpose: Register level tests of the serial control block
// Assumes: One AHB-Lite master and slave, slave model on the pins
// Notes:   Wait mode raised once to freeze a queued word
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import spi_cfg_pkg::*;
    logic        clock_i = 1'b0, rst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  haddr = 8'h00, s_rx;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic        hready, hresp, irq, sclk, sclk_oe, mosi, mosi_oe, miso, miso_oe;
    logic        sel_n, sel_n_oe, s_miso, wait_m = 1'b0, fault_n = 1'b1;
    int          n_mismatch = 0, comparisons = 0;
    // Wire levels; released clock pulled low, select up unless another master pulls it
    wire logic sclk_w = sclk_oe ? sclk : 1'b0;
    wire logic mosi_w = mosi_oe ? mosi : ~mosi;
    wire logic miso_w = miso_oe ? miso : s_miso;
    wire logic sel_n_w = sel_n_oe ? sel_n : fault_n;
    spi_control_config u_dut (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i({24'h0, haddr}), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .wait_mode_i(wait_m), .irq_o(irq), .sclk_i(sclk_w), .sclk_o(sclk),
        .sclk_oe_o(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
        .miso_i(miso_w), .miso_o(miso), .miso_oe_o(miso_oe), .sel_n_i(sel_n_w),
        .sel_n_o(sel_n), .sel_n_oe_o(sel_n_oe));
    spi_slave_model u_slave (.sclk_i(sclk_w), .sel_n_i(sel_n_w), .mosi_i(mosi_w),
        .miso_o(s_miso), .rx_o(s_rx));
    // 250 MHz clock
    initial forever #2 clock_i = ~clock_i;
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bounded wait for hready sampled high at an edge
    task automatic await_ready();
        int i;
        i = 0;
        do begin
            @(posedge clock_i);
            i++;
        end while (hready !== 1'b1 && i < 50);
        if (hready !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        await_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        await_ready();
        rd = hrdata;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        bus(0, ADDR_CTRL_ONE, 0);
        check("ctrl one", CTRL_ONE_RST, rd);
        bus(1, ADDR_CTRL_TWO, 8'hFF);
        bus(0, ADDR_CTRL_TWO, 0);
        check("ctrl two", 8'h1B, rd);
        bus(0, 8'h40, 0);
        check("unmapped", 0, rd);
        bus(1, ADDR_CTRL_ONE, 8'h60);
        repeat (3) @(posedge clock_i);
        check("irq on", 1, irq);
        bus(1, ADDR_CTRL_ONE, 8'h40);
        repeat (3) @(posedge clock_i);
        check("irq off", 0, irq);
        // Master words, 160 ns link period, both bit orders
        bus(1, ADDR_CTRL_TWO, 8'h10);
        bus(1, ADDR_BAUD, 8'h12);
        for (int k = 0; k < 2; k++) begin
            bus(1, ADDR_CTRL_ONE, k ? 8'hD3 : 8'h52);
            bus(0, ADDR_STATUS, 0);
            bus(1, ADDR_DATA, k ? 8'h35 : 8'h3C);
            for (int i = 0; i < 400 && rd[7] !== 1'b1; i++) bus(0, ADDR_STATUS, 0);
            check("rx full", 1, rd[7]);
            if (rd[7] !== 1'b1) finish_test();
            repeat (3) @(posedge clock_i);
            check("irq rx", k, irq);
            check("slave rx", k ? 8'hAC : 8'h3C, s_rx);
            bus(0, ADDR_DATA, 0);
            check("rx data", k ? 8'h69 : 8'h96, rd);
        end
        // Word queued while wait mode stops the clocks, then disabled mid-word
        bus(1, ADDR_CTRL_TWO, 8'h12);
        wait_m <= 1'b1;
        bus(0, ADDR_STATUS, 0);
        bus(1, ADDR_DATA, 8'h0F);
        repeat (40) @(posedge clock_i);
        bus(0, ADDR_STATUS, 0);
        check("wait frozen", 8'h00, rd);
        wait_m <= 1'b0;
        repeat (40) @(posedge clock_i);
        bus(1, ADDR_CTRL_ONE, 8'h00);
        bus(0, ADDR_STATUS, 0);
        check("status off", 8'h20, rd);
        check("pins off", 0, {sclk_oe, mosi_oe, miso_oe, sel_n_oe});
        // Another master pulls select low while in fault mode
        bus(1, ADDR_CTRL_ONE, 8'h50);
        fault_n <= 1'b0;
        repeat (6) @(posedge clock_i);
        bus(0, ADDR_STATUS, 0);
        check("fault status", 8'h30, rd);
        bus(0, ADDR_CTRL_ONE, 0);
        check("role dropped", 8'h40, rd);
        fault_n <= 1'b1;
        // Event interrupt unmasked, then cleared
        bus(1, ADDR_MASK, 8'h07);
        repeat (3) @(posedge clock_i);
        check("irq event", 1, irq);
        bus(1, ADDR_EVENT, 8'h07);
        repeat (3) @(posedge clock_i);
        check("irq clear", 0, irq);
        finish_test();
    end
endmodule
`default_nettype wire
